// ==== rtl/ebw_pkg.sv ====
package ebw_pkg;

  // Register indices and byte addresses
  localparam logic [7:0]  EBW_IDX_DELAY_CTRL  = 8'hA7;
  localparam logic [11:0] EBW_ADDR_DELAY_CTRL = {2'h0, EBW_IDX_DELAY_CTRL, 2'h0};
  localparam logic [11:0] EBW_ADDR_USER_CFG   = 12'h2A0;
  localparam logic [11:0] EBW_ADDR_STATUS     = 12'h2A4;

  // bus_delay_control fields
  localparam int          EBW_BIT_LIVE_HOLD   = 0;
  localparam int          EBW_BIT_PACE_EN     = 1;
  localparam logic [1:0]  EBW_DELAY_CTRL_RST  = 2'h0;

  // user_config_byte0 fields
  localparam int          EBW_CFG_RANGE_LSB   = 0;
  localparam int          EBW_CFG_PAGE_BIT    = 2;
  localparam logic [2:0]  EBW_USER_CFG_RST    = 3'h3;

  // Status fields
  localparam int          EBW_ST_BUSY         = 0;
  localparam int          EBW_ST_HOLDING      = 1;
  localparam int          EBW_ST_HOLD_PIN     = 2;
  localparam int          EBW_ST_SUPPRESSED   = 3;
  localparam int          EBW_ST_COUNT_LSB    = 8;

  // Write strobe address range codes
  localparam logic [1:0]  EBW_RANGE_NONE      = 2'h0;
  localparam logic [1:0]  EBW_RANGE_TOP_QTR   = 2'h1;
  localparam logic [1:0]  EBW_RANGE_TOP_HALF  = 2'h2;
  localparam logic [1:0]  EBW_RANGE_ALL       = 2'h3;

  // Pace clock: toggles every oscillator cycle, so runs at half rate
  localparam logic [3:0]  EBW_PACE_HALF_CYCLES = 4'h1;

  // Hold count saturation
  localparam logic [7:0]  EBW_HOLD_COUNT_MAX  = 8'hFF;

  typedef enum logic [2:0] {
    EBW_IDLE = 3'b000,
    EBW_ADDR = 3'b001,
    EBW_DATA = 3'b010,
    EBW_HOLD = 3'b011,
    EBW_DONE = 3'b100
  } ebw_state_t;

endpackage

// ==== rtl/ebw_pace_div.sv ====
`timescale 1ns/1ps
`default_nettype none

module ebw_pace_div (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  output var  logic paceOut
);

  logic [3:0] divCount_reg;
  logic       tick;

  // Divider producing a one-cycle tick every half period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount_reg <= 4'h0;
    end else if (!enable || divCount_reg == ebw_pkg::EBW_PACE_HALF_CYCLES - 4'h1) begin
      divCount_reg <= 4'h0;
    end else begin
      divCount_reg <= divCount_reg + 4'h1;
    end
  end

  assign tick = enable && (divCount_reg == ebw_pkg::EBW_PACE_HALF_CYCLES - 4'h1);

  // Square wave output, parked low while disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      paceOut <= 1'b0;
    end else if (!enable) begin
      paceOut <= 1'b0;
    end else if (tick) begin
      paceOut <= ~paceOut;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ebw_bus_ctrl.sv ====
// Behaviour
// - Hold input is honoured only once live_hold_enable (control bit 0) is set.
// - Memory drives hold input in real time; device uses it to finish cycle.
// - Pace clock output is driven only when pace_clock_enable (control bit 1) set.
// - Enabled pace clock is a square wave at half the oscillator rate.
// - Write strobe asserts only inside address range chosen by strobe_range_select.
// - Non-page mode: upper address on port 2, address/data multiplexed on port 0.
// - Page mode: low address on port 0; port 2 carries upper address then data.
`timescale 1ns/1ps
`default_nettype none

module ebw_bus_ctrl (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // User request side
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [15:0] reqAddr,
  input  wire logic [7:0]  reqWdata,
  output var  logic        reqReady,
  output var  logic        doneValid,
  output var  logic [7:0]  doneRdata,
  // External bus pins
  input  wire logic [7:0]  port0In,
  output var  logic [7:0]  port0Out,
  output var  logic        port0Oe,
  input  wire logic [7:0]  port2In,
  output var  logic [7:0]  port2Out,
  output var  logic        port2Oe,
  output var  logic        addrLatchEn,
  output var  logic        writeStrobe_n,
  input  wire logic        readyHoldIn_n,
  output var  logic        busPaceClockOut
);

  logic                rstMeta_n;
  logic                rstSync_n;
  logic [1:0]          delayCtrl_reg;
  logic [2:0]          userCfg_reg;
  logic                suppressed_reg;
  logic [7:0]          holdCount_reg;
  ebw_pkg::ebw_state_t state_reg;
  ebw_pkg::ebw_state_t state_next;
  logic                curWrite_reg;
  logic [15:0]         curAddr_reg;
  logic [7:0]          curWdata_reg;
  logic                curInRange_reg;
  logic                liveHoldEnable;
  logic                paceClockEnable;
  logic                pageMode;
  logic [1:0]          rangeSel;
  logic                holdActive;
  logic                reqInRange;
  logic                apbSetup;
  logic                apbWrite;
  logic                addrMapped;
  logic                statusClear;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // Configuration fields
  assign liveHoldEnable  = delayCtrl_reg[ebw_pkg::EBW_BIT_LIVE_HOLD];
  assign paceClockEnable = delayCtrl_reg[ebw_pkg::EBW_BIT_PACE_EN];
  assign pageMode        = userCfg_reg[ebw_pkg::EBW_CFG_PAGE_BIT];
  assign rangeSel        = userCfg_reg[ebw_pkg::EBW_CFG_RANGE_LSB +: 2];

  // Hold input counts only when enabled
  assign holdActive = liveHoldEnable && !readyHoldIn_n;

  // Address range qualification of the write strobe
  always_comb begin
    unique case (rangeSel)
      ebw_pkg::EBW_RANGE_NONE:     reqInRange = 1'b0;
      ebw_pkg::EBW_RANGE_TOP_QTR:  reqInRange = (reqAddr[15:14] == 2'h3);
      ebw_pkg::EBW_RANGE_TOP_HALF: reqInRange = reqAddr[15];
      ebw_pkg::EBW_RANGE_ALL:      reqInRange = 1'b1;
    endcase
  end

  // APB decode
  assign apbSetup   = psel && !penable;
  assign apbWrite   = psel && penable && pready && pwrite;
  assign addrMapped = (paddr == ebw_pkg::EBW_ADDR_DELAY_CTRL) ||
                      (paddr == ebw_pkg::EBW_ADDR_USER_CFG) ||
                      (paddr == ebw_pkg::EBW_ADDR_STATUS);
  assign statusClear = apbWrite && (paddr == ebw_pkg::EBW_ADDR_STATUS) &&
                       pwdata[ebw_pkg::EBW_ST_SUPPRESSED];

  // Answer in the first access cycle
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup && !addrMapped;
    end
  end

  // Read data captured at setup
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup) begin
      prdata <= 32'h0000_0000;
      if (paddr == ebw_pkg::EBW_ADDR_DELAY_CTRL) begin
        prdata[1:0] <= delayCtrl_reg;
      end else if (paddr == ebw_pkg::EBW_ADDR_USER_CFG) begin
        prdata[2:0] <= userCfg_reg;
      end else if (paddr == ebw_pkg::EBW_ADDR_STATUS) begin
        prdata[ebw_pkg::EBW_ST_BUSY]      <= (state_reg != ebw_pkg::EBW_IDLE);
        prdata[ebw_pkg::EBW_ST_HOLDING]   <= (state_reg == ebw_pkg::EBW_HOLD);
        prdata[ebw_pkg::EBW_ST_HOLD_PIN]  <= readyHoldIn_n;
        prdata[ebw_pkg::EBW_ST_SUPPRESSED] <= suppressed_reg;
        prdata[ebw_pkg::EBW_ST_COUNT_LSB +: 8] <= holdCount_reg;
      end
    end
  end

  // bus_delay_control register
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      delayCtrl_reg <= ebw_pkg::EBW_DELAY_CTRL_RST;
    end else if (apbWrite && paddr == ebw_pkg::EBW_ADDR_DELAY_CTRL) begin
      delayCtrl_reg <= pwdata[1:0];
    end
  end

  // user_config_byte0 register
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      userCfg_reg <= ebw_pkg::EBW_USER_CFG_RST;
    end else if (apbWrite && paddr == ebw_pkg::EBW_ADDR_USER_CFG) begin
      userCfg_reg <= pwdata[2:0];
    end
  end

  // Sticky flag for writes made without strobe; a new event beats the clear
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      suppressed_reg <= 1'b0;
    end else if (state_reg == ebw_pkg::EBW_IDLE && reqValid && reqReady && reqWrite && !reqInRange) begin
      suppressed_reg <= 1'b1;
    end else if (statusClear) begin
      suppressed_reg <= 1'b0;
    end
  end

  // Cycle sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ebw_pkg::EBW_IDLE: begin
        if (reqValid && reqReady) begin
          state_next = ebw_pkg::EBW_ADDR;
        end
      end
      ebw_pkg::EBW_ADDR: begin
        state_next = ebw_pkg::EBW_DATA;
      end
      ebw_pkg::EBW_DATA: begin
        state_next = holdActive ? ebw_pkg::EBW_HOLD : ebw_pkg::EBW_DONE;
      end
      ebw_pkg::EBW_HOLD: begin
        state_next = holdActive ? ebw_pkg::EBW_HOLD : ebw_pkg::EBW_DONE;
      end
      ebw_pkg::EBW_DONE: begin
        state_next = ebw_pkg::EBW_IDLE;
      end
      default: begin
        state_next = ebw_pkg::EBW_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_reg <= ebw_pkg::EBW_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Request capture
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      curWrite_reg   <= 1'b0;
      curAddr_reg    <= 16'h0000;
      curWdata_reg   <= 8'h00;
      curInRange_reg <= 1'b0;
    end else if (state_reg == ebw_pkg::EBW_IDLE && reqValid && reqReady) begin
      curWrite_reg   <= reqWrite;
      curAddr_reg    <= reqAddr;
      curWdata_reg   <= reqWdata;
      curInRange_reg <= reqInRange;
    end
  end

  // Request ready only while idle and not about to start
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= (state_next == ebw_pkg::EBW_IDLE) && !(state_reg == ebw_pkg::EBW_IDLE && reqValid && reqReady);
    end
  end

  // Hold extension counter, restarted per cycle, saturating
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      holdCount_reg <= 8'h00;
    end else if (state_reg == ebw_pkg::EBW_ADDR) begin
      holdCount_reg <= 8'h00;
    end else if (state_next == ebw_pkg::EBW_HOLD && holdCount_reg != ebw_pkg::EBW_HOLD_COUNT_MAX) begin
      holdCount_reg <= holdCount_reg + 8'h01;
    end
  end

  // Completion pulse and read data, taken when the hold releases
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      doneValid <= 1'b0;
      doneRdata <= 8'h00;
    end else begin
      doneValid <= (state_next == ebw_pkg::EBW_DONE);
      if (state_next == ebw_pkg::EBW_DONE && !curWrite_reg) begin
        doneRdata <= pageMode ? port2In : port0In;
      end
    end
  end

  // Port 0 drive
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      port0Out <= 8'h00;
      port0Oe  <= 1'b0;
    end else begin
      unique case (state_next)
        ebw_pkg::EBW_ADDR: begin
          port0Out <= reqAddr[7:0];
          port0Oe  <= 1'b1;
        end
        ebw_pkg::EBW_DATA, ebw_pkg::EBW_HOLD: begin
          if (pageMode) begin
            port0Out <= curAddr_reg[7:0];
            port0Oe  <= 1'b1;
          end else begin
            port0Out <= curWdata_reg;
            port0Oe  <= curWrite_reg;
          end
        end
        default: begin
          port0Out <= 8'h00;
          port0Oe  <= 1'b0;
        end
      endcase
    end
  end

  // Port 2 drive
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      port2Out <= 8'h00;
      port2Oe  <= 1'b0;
    end else begin
      unique case (state_next)
        ebw_pkg::EBW_ADDR: begin
          port2Out <= reqAddr[15:8];
          port2Oe  <= 1'b1;
        end
        ebw_pkg::EBW_DATA, ebw_pkg::EBW_HOLD: begin
          if (pageMode) begin
            port2Out <= curWdata_reg;
            port2Oe  <= curWrite_reg;
          end else begin
            port2Out <= curAddr_reg[15:8];
            port2Oe  <= 1'b1;
          end
        end
        default: begin
          port2Out <= 8'h00;
          port2Oe  <= 1'b0;
        end
      endcase
    end
  end

  // Address latch enable and qualified write strobe
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      addrLatchEn   <= 1'b0;
      writeStrobe_n <= 1'b1;
    end else begin
      addrLatchEn   <= (state_next == ebw_pkg::EBW_ADDR);
      writeStrobe_n <= !((state_next == ebw_pkg::EBW_DATA || state_next == ebw_pkg::EBW_HOLD) &&
                         curWrite_reg && curInRange_reg);
    end
  end

  // Pace clock generator
  ebw_pace_div u_pace (
    .clk     (mclk),
    .rst_n   (rstSync_n),
    .enable  (paceClockEnable),
    .paceOut (busPaceClockOut)
  );

endmodule

`default_nettype wire

// ==== dv/ebw_bus_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module ebw_bus_checker (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [7:0]  port0Out,
  input wire logic        port0Oe,
  input wire logic [7:0]  port2Out,
  input wire logic        port2Oe,
  input wire logic        addrLatchEn,
  input wire logic        writeStrobe_n,
  input wire logic        readyHoldIn_n,
  input wire logic        doneValid,
  input wire logic        busPaceClockOut
);
  logic [1:0] ctlReg;
  logic [2:0] cfgReg;
  logic [7:0] hiReg;
  logic       wrEn;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Completed register writes
  assign wrEn = psel && penable && pready && pwrite;

  // Shadow of control and config fields
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctlReg <= 2'h0;
      cfgReg <= 3'h3;
    end else if (wrEn && paddr == ebw_pkg::EBW_ADDR_DELAY_CTRL) begin
      ctlReg <= pwdata[1:0];
    end else if (wrEn && paddr == ebw_pkg::EBW_ADDR_USER_CFG) begin
      cfgReg <= pwdata[2:0];
    end
  end

  // Upper address of the running cycle
  always_ff @(posedge mclk) begin
    if (addrLatchEn) begin
      hiReg <= port2Out;
    end
  end

  pace_gate_a: assert property (!ctlReg[1] [*4] |-> !busPaceClockOut)
    else $error("pace clock runs while disabled");
  pace_half_a: assert property (ctlReg[1] [*3] |-> busPaceClockOut != $past(busPaceClockOut))
    else $error("pace clock missed a toggle");
  hold_done_a: assert property ((!ctlReg[0] || readyHoldIn_n) && !writeStrobe_n |=> doneValid)
    else $error("ready cycle did not complete");
  hold_extend_a: assert property (ctlReg[0] && !readyHoldIn_n && !writeStrobe_n |=> !doneValid && !writeStrobe_n)
    else $error("held cycle was not extended");
  strobe_range_a: assert property ($fell(writeStrobe_n) |-> cfgReg[1:0] == 2'h3 ||
      (cfgReg[1:0] == 2'h2 && hiReg[7]) || (cfgReg[1:0] == 2'h1 && hiReg[7:6] == 2'h3))
    else $error("write strobe outside range");
  nonpage_port_a: assert property ($fell(addrLatchEn) && !cfgReg[2] |-> port2Oe && port2Out == $past(port2Out))
    else $error("port 2 lost upper address");
  page_port_a: assert property ($fell(addrLatchEn) && cfgReg[2] |-> port0Oe && port0Out == $past(port0Out))
    else $error("port 0 lost low address");
  addr_drive_a: assert property (addrLatchEn |-> port0Oe && port2Oe)
    else $error("address not driven");
endmodule

bind ebw_bus_ctrl ebw_bus_checker chk (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .port0Out(port0Out), .port0Oe(port0Oe),
  .port2Out(port2Out), .port2Oe(port2Oe), .addrLatchEn(addrLatchEn), .writeStrobe_n(writeStrobe_n),
  .readyHoldIn_n(readyHoldIn_n), .doneValid(doneValid), .busPaceClockOut(busPaceClockOut));

`default_nettype wire

// ==== dv/ebw_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ebw_mem_model (
  input  wire logic       mclk,
  input  wire logic       pageMode,
  input  wire logic [3:0] holdCycles,
  input  wire logic [7:0] port0Out,
  input  wire logic       port0Oe,
  input  wire logic [7:0] port2Out,
  input  wire logic       port2Oe,
  input  wire logic       addrLatchEn,
  input  wire logic       writeStrobe_n,
  output var  logic [7:0] port0In,
  output var  logic [7:0] port2In,
  output var  logic       readyHoldIn_n
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addrReg;
  logic [3:0]  cntReg;
  logic        inCycReg = 1'b0;
  logic [7:0]  lastReg  = 8'h00;

  // Latch address, count hold cycles, end the cycle
  always_ff @(posedge mclk) begin
    if (addrLatchEn) begin
      addrReg  <= {port2Out, port0Out};
      cntReg   <= holdCycles;
      inCycReg <= 1'b1;
    end else if (inCycReg && cntReg != 4'h0) begin
      cntReg <= cntReg - 4'h1;
    end else if (inCycReg) begin
      inCycReg <= 1'b0;
      lastReg  <= pageMode ? port2In : port0In;
    end
  end

  // Store data on every edge the strobe is low, held or not
  always_ff @(posedge mclk) begin
    if (!writeStrobe_n) begin
      mem[addrReg] <= pageMode ? port2Out : port0Out;
    end
  end

  // Not ready while hold count runs
  assign readyHoldIn_n = !(inCycReg && !addrLatchEn && cntReg != 4'h0);

  // Released lines show memory data on the cycle's data port, else the inverse of the last data
  assign port0In = port0Oe ? port0Out : (inCycReg && !pageMode ? mem[addrReg] : ~lastReg);
  assign port2In = port2Oe ? port2Out : (inCycReg && pageMode ? mem[addrReg] : ~lastReg);
endmodule

`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        mclk = 1'b0;
  logic        reset_n, psel, penable, pwrite, reqValid, reqWrite, pageMode, e, s;
  logic        pready, pslverr, reqReady, doneValid, port0Oe, port2Oe, addrLatchEn, writeStrobe_n;
  logic        readyHoldIn_n, busPaceClockOut;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] reqAddr;
  logic [7:0]  reqWdata, doneRdata, port0In, port0Out, port2In, port2Out;
  logic [3:0]  holdCycles;
  logic [15:0] ad [3] = '{16'hC012, 16'h8034, 16'h1056};
  int          nMismatch = 0;
  int          nTests = 0;
  int          cyc, t;

  ebw_bus_ctrl dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .doneValid(doneValid),
    .doneRdata(doneRdata), .port0In(port0In), .port0Out(port0Out), .port0Oe(port0Oe), .port2In(port2In),
    .port2Out(port2Out), .port2Oe(port2Oe), .addrLatchEn(addrLatchEn), .writeStrobe_n(writeStrobe_n),
    .readyHoldIn_n(readyHoldIn_n), .busPaceClockOut(busPaceClockOut));

  ebw_mem_model mem (.mclk(mclk), .pageMode(pageMode), .holdCycles(holdCycles), .port0Out(port0Out),
    .port0Oe(port0Oe), .port2Out(port2Out), .port2Oe(port2Oe), .addrLatchEn(addrLatchEn),
    .writeStrobe_n(writeStrobe_n), .port0In(port0In), .port2In(port2In), .readyHoldIn_n(readyHoldIn_n));

  // 25 MHz clock
  always #20 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, result left in r and e
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1 && ++k < 50);
    chk(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One external byte cycle; cyc counts edges to done, s notes a strobe
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    int k;
    k = 0;
    s = 1'b0;
    cyc = 0;
    @(posedge mclk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr  <= a;
    reqWdata <= d;
    do @(posedge mclk); while (reqReady !== 1'b1 && ++k < 50);
    reqValid <= 1'b0;
    do begin
      @(posedge mclk);
      cyc++;
      if (writeStrobe_n === 1'b0) s = 1'b1;
    end while (doneValid !== 1'b1 && cyc < 50);
    chk(doneValid, 1'b1);
  endtask

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {reset_n, psel, penable, pwrite, reqValid, reqWrite, pageMode} = '0;
    paddr = '0;
    pwdata = '0;
    reqAddr = '0;
    reqWdata = '0;
    holdCycles = 4'h0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, ebw_pkg::EBW_ADDR_DELAY_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, ebw_pkg::EBW_ADDR_USER_CFG, 32'h0);
    chk(r, 32'h3);
    apb(1'b1, 12'h3F0, 32'hFFFFFFFF);
    apb(1'b0, 12'h3F0, 32'h0);
    chk({r[31:1], e}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ebw_pkg::EBW_ADDR_USER_CFG, 32'(c));
      for (int i = 0; i < 3; i++) begin
        xfer(1'b1, ad[i], 8'h5A);
        chk(s, c == 3 || (c == 2 && ad[i][15]) || (c == 1 && ad[i][15:14] == 2'h3));
      end
    end
    // Out-of-range writes left the sticky flag; hold pin idles high
    apb(1'b0, ebw_pkg::EBW_ADDR_STATUS, 32'h0);
    chk(r, 32'h0000_000C);
    apb(1'b1, ebw_pkg::EBW_ADDR_STATUS, 32'h0000_0008);
    apb(1'b0, ebw_pkg::EBW_ADDR_STATUS, 32'h0);
    chk(r, 32'h0000_0004);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, ebw_pkg::EBW_ADDR_USER_CFG, 32'h3 | (32'(p) << 2));
      pageMode <= p[0];
      xfer(1'b1, 16'h7100 + 16'(p), 8'hC3 ^ 8'(p));
      xfer(1'b0, 16'h7100 + 16'(p), 8'h00);
      chk(doneRdata, 8'hC3 ^ 8'(p));
    end
    holdCycles <= 4'h3;
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, ebw_pkg::EBW_ADDR_DELAY_CTRL, 32'(h));
      xfer(1'b1, 16'hF0F0, 8'h96 + 8'(h));
      chk(32'(cyc), 32'(3 + 3 * h));
      xfer(1'b0, 16'hF0F0, 8'h00);
      chk(doneRdata, 8'h96 + 8'(h));
      chk(32'(cyc), 32'(3 + 3 * h));
    end
    // Last cycle was held three cycles
    apb(1'b0, ebw_pkg::EBW_ADDR_STATUS, 32'h0);
    chk(r, 32'h0000_0304);
    apb(1'b1, ebw_pkg::EBW_ADDR_DELAY_CTRL, 32'h2);
    repeat (3) @(posedge mclk);
    t = 0;
    repeat (16) begin
      e = busPaceClockOut;
      @(posedge mclk);
      t += int'(busPaceClockOut !== e);
    end
    chk(32'(t), 32'h10);
    apb(1'b1, ebw_pkg::EBW_ADDR_DELAY_CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    t = 0;
    repeat (16) begin
      @(posedge mclk);
      t += int'(busPaceClockOut !== 1'b0);
    end
    chk(32'(t), 32'h0);
    give_verdict;
  end

  // Cut a hang short
  initial begin
    #(40 * 5000);
    nMismatch++;
    give_verdict;
  end
endmodule

`default_nettype wire
